// ===== shared/upmc_defs.svh
// Offsets, field positions and reset values of the serial port mode registers.
`ifndef UPMC_DEFS_SVH
`define UPMC_DEFS_SVH

// Configuration index of the logical device select register.
`define UPMC_IDX_LDN    8'h07
// Configuration index of the mode register inside each serial logical device.
`define UPMC_IDX_MODE   8'hf0
// Logical device numbers of the third and fourth serial ports.
`define UPMC_LDN_UART3  8'h0b
`define UPMC_LDN_UART4  8'h0c

// Reset values.
`define UPMC_MODE_RST   8'h00
`define UPMC_LDN_RST    8'h00

// Field positions inside a mode register.
`define UPMC_BIT_MIDI   0
`define UPMC_BIT_HS     1
`define UPMC_BIT_FRQ_LO 2
`define UPMC_BIT_FRQ_HI 3
`define UPMC_BIT_SHARE  7

`endif

// ===== shared/upmc_pkg.sv
// Types shared by the serial port mode configuration block.
package upmc_pkg;

  // Enhanced frequency selection codes of the mode register.
  typedef enum logic [1:0] {
    UPMC_FRQ_STD  = 2'h0,
    UPMC_FRQ_921K = 2'h1,
    UPMC_FRQ_1M5  = 2'h2,
    UPMC_FRQ_RSVD = 2'h3
  } upmc_freq_t;

endpackage : upmc_pkg

// ===== shared/upmc_cfg_if.sv
// Connection between the register decoder and one mode register store.
`timescale 1ns/1ns
interface upmc_cfg_if;
  logic       wr_en;
  logic [7:0] wdata;
  logic       clr;
  logic [7:0] q;

  modport ctl   (output wr_en, output wdata, output clr, input q);
  modport store (input wr_en, input wdata, input clr, output q);
endinterface : upmc_cfg_if

// ===== design/upmc_mode_reg.sv
// One 8-bit serial port mode register with synchronous clear and write.
`timescale 1ns/1ns
`include "upmc_defs.svh"
module upmc_mode_reg
  import upmc_pkg::*;
(
  input wire logic     ref_clk,
  input wire logic     rst,
  upmc_cfg_if.store    bus
);

  logic [7:0] mode_reg;

  // ************************************************************
  // Storage
  // ************************************************************

  // A supply or bus reset clears the register ahead of any write in the same
  // cycle, so software can never leave a stale mode behind a reset.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= `UPMC_MODE_RST;
    end else if (bus.clr) begin
      mode_reg <= `UPMC_MODE_RST;
    end else if (bus.wr_en) begin
      mode_reg <= bus.wdata;
    end
  end

  // Every bit reads back as written, test bits included.
  assign bus.q = mode_reg;

endmodule : upmc_mode_reg

// ===== design/upmc_top.sv
// Mode configuration registers of the third and fourth serial ports.
//
// Contract
// - Both mode registers clear to zero on any power-on or bus reset.
// - Bit 0 enables MIDI support on extended-port variants; clear by default.
// - Bit 1 enables high-speed operation on extended-port variants.
// - Bits 3:2 pick standard, 921K or 1.5M on extended-port variants; code 11 is never programmed.
// - Bit 7 of the third port register makes both UARTs share one request on extended-port variants.
// - Registers sit at index f0 of logical devices 0b and 0c.
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`include "upmc_defs.svh"
module upmc_top
  import upmc_pkg::*;
#(
  parameter bit EXT_PORTS = 1'b1
)
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       vtr_por_in,
  input  wire logic       pci_rst_in,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  input  wire logic       cfg_wr,
  input  wire logic       cfg_rd,
  output      logic [7:0] cfg_rdata,
  input  wire logic       uart3_irq_in,
  input  wire logic       uart4_irq_in,
  output      logic       u3_midi_en,
  output      logic       u3_hs_en,
  output      logic [1:0] u3_freq_sel,
  output      logic       u4_midi_en,
  output      logic       u4_hs_en,
  output      logic [1:0] u4_freq_sel,
  output      logic       irq_share,
  output      logic       uart3_irq_out,
  output      logic       uart4_irq_out
);

  // ************************************************************
  // Reset pins
  // ************************************************************

  logic [1:0] vtr_sync_reg;
  logic [1:0] pci_sync_reg;
  logic       sync_clr;

  // The standby supply and bus reset pins are foreign to this clock, so each
  // passes two flip-flops before it may clear anything.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vtr_sync_reg <= 2'h0;
      pci_sync_reg <= 2'h0;
    end else begin
      vtr_sync_reg <= {vtr_sync_reg[0], vtr_por_in};
      pci_sync_reg <= {pci_sync_reg[0], pci_rst_in};
    end
  end

  // Any of the three resets clears the configuration.
  assign sync_clr = vtr_sync_reg[1] | pci_sync_reg[1];

  // ************************************************************
  // Logical device select
  // ************************************************************

  logic [7:0] ldn_reg;

  // The device number picks which bank answers at index f0.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ldn_reg <= `UPMC_LDN_RST;
    end else if (sync_clr) begin
      ldn_reg <= `UPMC_LDN_RST;
    end else if (cfg_wr && cfg_addr == `UPMC_IDX_LDN) begin
      ldn_reg <= cfg_wdata;
    end
  end

  // ************************************************************
  // Address decode
  // ************************************************************

  logic sel_u3;
  logic sel_u4;

  // Index f0 alone is ambiguous; the logical device number settles it.
  assign sel_u3 = (cfg_addr == `UPMC_IDX_MODE) &&
                  (ldn_reg == `UPMC_LDN_UART3);
  assign sel_u4 = (cfg_addr == `UPMC_IDX_MODE) &&
                  (ldn_reg == `UPMC_LDN_UART4);

  // ************************************************************
  // Mode register stores
  // ************************************************************

  upmc_cfg_if u3_bus ();
  upmc_cfg_if u4_bus ();

  // Reserved and test bits are stored as written; software keeps them zero,
  // and only the read port returns them.
  assign u3_bus.wr_en = cfg_wr && sel_u3;
  assign u3_bus.wdata = cfg_wdata;
  assign u3_bus.clr   = sync_clr;
  assign u4_bus.wr_en = cfg_wr && sel_u4;
  assign u4_bus.wdata = cfg_wdata;
  assign u4_bus.clr   = sync_clr;

  upmc_mode_reg u3_store (
    .ref_clk (ref_clk),
    .rst     (rst),
    .bus     (u3_bus.store)
  );

  upmc_mode_reg u4_store (
    .ref_clk (ref_clk),
    .rst     (rst),
    .bus     (u4_bus.store)
  );

  // ************************************************************
  // Read port
  // ************************************************************

  logic [7:0] rdata_next;

  // Unmapped indices read as zero.
  always_comb begin
    rdata_next = 8'h00;
    if (cfg_addr == `UPMC_IDX_LDN) begin
      rdata_next = ldn_reg;
    end else if (sel_u3) begin
      rdata_next = u3_bus.q;
    end else if (sel_u4) begin
      rdata_next = u4_bus.q;
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      cfg_rdata <= rdata_next;
    end else begin
      cfg_rdata <= 8'h00;
    end
  end

  // ************************************************************
  // Field decode
  // ************************************************************

  // The reserved frequency code falls back to standard, which is the safe
  // baud base if software breaks its side of the deal.
  function automatic logic [1:0] upmc_freq_map(input logic [1:0] code);
    upmc_freq_map = (code == UPMC_FRQ_RSVD) ? UPMC_FRQ_STD : code;
  endfunction : upmc_freq_map

  // On the two-port variant every bit is a test bit, so no mode reaches
  // the UARTs there.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      u3_midi_en  <= 1'b0;
      u3_hs_en    <= 1'b0;
      u3_freq_sel <= 2'h0;
      u4_midi_en  <= 1'b0;
      u4_hs_en    <= 1'b0;
      u4_freq_sel <= 2'h0;
    end else begin
      u3_midi_en  <= EXT_PORTS & u3_bus.q[`UPMC_BIT_MIDI];
      u3_hs_en    <= EXT_PORTS & u3_bus.q[`UPMC_BIT_HS];
      u4_midi_en  <= EXT_PORTS & u4_bus.q[`UPMC_BIT_MIDI];
      u4_hs_en    <= EXT_PORTS & u4_bus.q[`UPMC_BIT_HS];
      u3_freq_sel <= EXT_PORTS ?
        upmc_freq_map(u3_bus.q[`UPMC_BIT_FRQ_HI:`UPMC_BIT_FRQ_LO]) : 2'h0;
      u4_freq_sel <= EXT_PORTS ?
        upmc_freq_map(u4_bus.q[`UPMC_BIT_FRQ_HI:`UPMC_BIT_FRQ_LO]) : 2'h0;
    end
  end

  // ************************************************************
  // Interrupt routing
  // ************************************************************

  logic share_now;

  // Only the third port register carries the sharing control.
  assign share_now = EXT_PORTS & u3_bus.q[`UPMC_BIT_SHARE];

  // While shared, the fourth request line rests low and the third carries
  // both; the UART status registers still name the source.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_share     <= 1'b0;
      uart3_irq_out <= 1'b0;
      uart4_irq_out <= 1'b0;
    end else begin
      irq_share     <= share_now;
      uart3_irq_out <= uart3_irq_in | (share_now & uart4_irq_in);
      uart4_irq_out <= ~share_now & uart4_irq_in;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************

  default clocking upmc_cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  AST_CLEAR_BOTH: assert property (
    sync_clr |=> (u3_bus.q == 8'h00) && (u4_bus.q == 8'h00) ##1
      !u3_midi_en && !u4_hs_en && (u3_freq_sel == 2'h0))
    else $error("Mode register not cleared by reset pin.");

  AST_U3_WRITE: assert property (
    (cfg_wr && cfg_addr == 8'hf0 && ldn_reg == 8'h0b && !sync_clr)
      |=> u3_bus.q == $past(cfg_wdata))
    else $error("Third port register missed its write.");

  AST_U4_WRITE: assert property (
    (cfg_wr && cfg_addr == 8'hf0 && ldn_reg == 8'h0c && !sync_clr)
      |=> u4_bus.q == $past(cfg_wdata) && $stable(u3_bus.q))
    else $error("Fourth port register missed its write.");

  AST_OTHER_LDN: assert property (
    (cfg_wr && ldn_reg != 8'h0b && ldn_reg != 8'h0c && !sync_clr)
      |=> $stable(u3_bus.q) && $stable(u4_bus.q))
    else $error("Mode register written from another device.");

  AST_MIDI_FOLLOW: assert property (
    ##1 u3_midi_en == (EXT_PORTS && $past(u3_bus.q[0])))
    else $error("MIDI enable does not follow bit 0.");

  AST_HS_FOLLOW: assert property (
    ##1 u4_hs_en == (EXT_PORTS && $past(u4_bus.q[1])))
    else $error("High speed enable does not follow bit 1.");

  AST_FREQ_SEL: assert property (
    (EXT_PORTS && u3_bus.q[3:2] == 2'h2) |=> u3_freq_sel == 2'h2)
    else $error("1.5M select not passed on.");

  AST_SHARE_MERGE: assert property (
    (u3_bus.q[7] && EXT_PORTS && uart4_irq_in)
      |=> uart3_irq_out && !uart4_irq_out)
    else $error("Shared request did not merge.");

  AST_SPLIT_IRQ: assert property (
    !u3_bus.q[7] |=> uart4_irq_out == $past(uart4_irq_in)
      && uart3_irq_out == $past(uart3_irq_in))
    else $error("Separate requests not kept apart.");

  AST_READ_WINDOW: assert property (
    (cfg_rd && sel_u3) |=> cfg_rdata == $past(u3_bus.q) ##1
      (cfg_rdata == 8'h00 || $past(cfg_rd)))
    else $error("Read data not confined to one cycle.");

  COV_U3_WRITE: cover property (cfg_wr && sel_u3);
  COV_U4_READ: cover property (cfg_rd && sel_u4);
  COV_SHARED: cover property (share_now && uart4_irq_in);
  COV_PIN_CLR: cover property (sync_clr && u3_bus.q != 8'h00);

endmodule : upmc_top

// ===== sim/upmc_tb.sv
// Self-checking bench of the serial port mode configuration registers.
`timescale 1ns/1ns
`include "upmc_defs.svh"
module testbench;
  logic       ref_clk, rst, vtr_por_in, pci_rst_in, cfg_wr, cfg_rd;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, d;
  logic       uart3_irq_in, uart4_irq_in, uart3_irq_out, uart4_irq_out, irq_share;
  logic       u3_midi_en, u3_hs_en, u4_midi_en, u4_hs_en;
  logic [1:0] u3_freq_sel, u4_freq_sel;
  int         error_cnt = 0;
  int         checked = 0;

  // Only the four-port variant is built, so no write here falls under the
  // all-zero rule of the two-port variant.
  upmc_top dut (.ref_clk(ref_clk), .rst(rst), .vtr_por_in(vtr_por_in),
    .pci_rst_in(pci_rst_in), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .uart3_irq_in(uart3_irq_in), .uart4_irq_in(uart4_irq_in),
    .u3_midi_en(u3_midi_en), .u3_hs_en(u3_hs_en), .u3_freq_sel(u3_freq_sel),
    .u4_midi_en(u4_midi_en), .u4_hs_en(u4_hs_en), .u4_freq_sel(u4_freq_sel),
    .irq_share(irq_share), .uart3_irq_out(uart3_irq_out),
    .uart4_irq_out(uart4_irq_out));

  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  // The field outputs of each port gathered into one byte for comparison.
  function automatic logic [7:0] f3();
    return {4'h0, u3_freq_sel, u3_hs_en, u3_midi_en};
  endfunction : f3
  function automatic logic [7:0] f4();
    return {4'h0, u4_freq_sel, u4_hs_en, u4_midi_en};
  endfunction : f4

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Moves one edge on and settles, so flags are never read in a launch step.
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    cfg_addr  <= a;
    cfg_wdata <= v;
    cfg_wr    <= 1'b1;
    @(posedge ref_clk);
    cfg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    cfg_addr <= a;
    cfg_rd   <= 1'b1;
    @(posedge ref_clk);
    cfg_rd   <= 1'b0;
    #1;
    v = cfg_rdata;
  endtask : rd

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // ****************************************
  // Tests
  // ****************************************
  task automatic t_fields();
    for (int p = 0; p < 2; p++) begin
      wr(`UPMC_IDX_LDN, p ? `UPMC_LDN_UART4 : `UPMC_LDN_UART3);
      rd(`UPMC_IDX_MODE, d);
      chk(d, 8'h00);
      // Codes 0..11 walk every legal frequency code with both enables.
      for (int v = 0; v < 12; v++) begin
        wr(`UPMC_IDX_MODE, 8'(v));
        step();
        chk(p ? f4() : f3(), 8'(v));
        rd(`UPMC_IDX_MODE, d);
        chk(d, 8'(v));
      end
    end
    chk(f3(), 8'h0b);
    $display("fields test done");
  endtask : t_fields

  task automatic t_share();
    wr(`UPMC_IDX_LDN, `UPMC_LDN_UART3);
    for (int s = 0; s < 2; s++) begin
      wr(`UPMC_IDX_MODE, {s[0], 7'h00});
      step();
      chk({7'h00, irq_share}, {7'h00, s[0]});
      for (int k = 0; k < 4; k++) begin
        @(posedge ref_clk);
        uart3_irq_in <= k[0];
        uart4_irq_in <= k[1];
        step();
        chk({6'h00, uart3_irq_out, uart4_irq_out},
            {6'h00, k[0] | (s[0] & k[1]), k[1] & ~s[0]});
      end
    end
    $display("share test done");
  endtask : t_share

  task automatic t_decode();
    wr(8'hf1, 8'h55);
    rd(8'hf1, d);
    chk(d, 8'h00);
    rd(`UPMC_IDX_MODE, d);
    chk(d, 8'h80);
    step();
    chk(cfg_rdata, 8'h00);
    // A foreign logical device must neither read nor take the mode index.
    wr(`UPMC_IDX_LDN, 8'h0a);
    rd(`UPMC_IDX_LDN, d);
    chk(d, 8'h0a);
    wr(`UPMC_IDX_MODE, 8'h03);
    rd(`UPMC_IDX_MODE, d);
    chk(d, 8'h00);
    wr(`UPMC_IDX_LDN, `UPMC_LDN_UART3);
    rd(`UPMC_IDX_MODE, d);
    chk(d, 8'h80);
    wr(`UPMC_IDX_LDN, `UPMC_LDN_UART4);
    rd(`UPMC_IDX_MODE, d);
    chk(d, 8'h0b);
    $display("decode test done");
  endtask : t_decode

  // Each reset source in turn: 0 standby pin, 1 bus pin, 2 main reset.
  task automatic t_resets();
    for (int r = 0; r < 3; r++) begin
      wr(`UPMC_IDX_LDN, `UPMC_LDN_UART3);
      wr(`UPMC_IDX_MODE, 8'h86);
      wr(`UPMC_IDX_LDN, `UPMC_LDN_UART4);
      wr(`UPMC_IDX_MODE, 8'h05);
      @(posedge ref_clk);
      if (r == 0) vtr_por_in <= 1'b1;
      else if (r == 1) pci_rst_in <= 1'b1;
      else rst <= 1'b1;
      repeat (4) step();
      chk(f3(), 8'h00);
      chk({7'h00, irq_share}, 8'h00);
      chk(f4(), 8'h00);
      @(posedge ref_clk);
      vtr_por_in <= 1'b0;
      pci_rst_in <= 1'b0;
      rst        <= 1'b0;
      repeat (4) step();
      // Every reset clears the device select too, so pick the third port again.
      wr(`UPMC_IDX_LDN, `UPMC_LDN_UART3);
      rd(`UPMC_IDX_MODE, d);
      chk(d, 8'h00);
      wr(`UPMC_IDX_LDN, `UPMC_LDN_UART4);
      rd(`UPMC_IDX_MODE, d);
      chk(d, 8'h00);
    end
    $display("reset test done");
  endtask : t_resets

  // ****************************************
  // Clock, sequence and watchdog
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    rst          = 1'b1;
    vtr_por_in   = 1'b0;
    pci_rst_in   = 1'b0;
    cfg_addr     = 8'h00;
    cfg_wdata    = 8'h00;
    cfg_wr       = 1'b0;
    cfg_rd       = 1'b0;
    uart3_irq_in = 1'b0;
    uart4_irq_in = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_fields();
    t_share();
    t_decode();
    t_resets();
    conclude();
  end

  // The tests need under 300 cycles; a hundred times that marks a hang.
  initial begin
    #300000;
    error_cnt++;
    conclude();
  end
endmodule : testbench
